// [verilog/jlpr_pkg.sv]
// Purpose: Shared constants and carriers for the link parameter register bank.
// Assumes: Register accesses arrive already decoded from the serial control port.
// Notes:   Reset values and masks are held here so the bank and its bench agree.
package jlpr_pkg;

	localparam int unsigned ADDR_W = 13;
	localparam int unsigned DATA_W = 8;

	// Register addresses.
	localparam logic [ADDR_W-1:0] A_BANK_ID   = 13'h0065;
	localparam logic [ADDR_W-1:0] A_LANE0_ID  = 13'h0066;
	localparam logic [ADDR_W-1:0] A_LANE1_ID  = 13'h0067;
	localparam logic [ADDR_W-1:0] A_SCR_LANE  = 13'h006E;
	localparam logic [ADDR_W-1:0] A_OCTETS    = 13'h006F;
	localparam logic [ADDR_W-1:0] A_FRAMES_MF = 13'h0070;
	localparam logic [ADDR_W-1:0] A_CONV      = 13'h0071;
	localparam logic [ADDR_W-1:0] A_RES_CTRL  = 13'h0072;
	localparam logic [ADDR_W-1:0] A_TOT_BITS  = 13'h0073;
	localparam logic [ADDR_W-1:0] A_SAMPLES   = 13'h0074;
	localparam logic [ADDR_W-1:0] A_DENSITY   = 13'h0075;
	localparam logic [ADDR_W-1:0] A_SCRATCH1  = 13'h0076;
	localparam logic [ADDR_W-1:0] A_SCRATCH2  = 13'h0077;
	localparam logic [ADDR_W-1:0] A_CHK0      = 13'h0078;
	localparam logic [ADDR_W-1:0] A_CHK1      = 13'h0079;

	// Writable bits of each register; open bits read as zero.
	localparam logic [DATA_W-1:0] M_BANK_ID   = 8'h0F;
	localparam logic [DATA_W-1:0] M_LANE_ID   = 8'h1F;
	localparam logic [DATA_W-1:0] M_SCR_LANE  = 8'h81;
	localparam logic [DATA_W-1:0] M_FRAMES_MF = 8'h1F;
	localparam logic [DATA_W-1:0] M_CONV      = 8'h01;
	localparam logic [DATA_W-1:0] M_RES_CTRL  = 8'hDF;
	localparam logic [DATA_W-1:0] M_FULL      = 8'hFF;

	// Field positions.
	localparam int unsigned B_SCR_EN   = 7;
	localparam int unsigned B_TWO_LANE = 0;
	localparam int unsigned B_TWO_CONV = 0;

	// Reset values.
	localparam logic [DATA_W-1:0] R_ZERO      = 8'h00;
	localparam logic [DATA_W-1:0] R_SCR_LANE  = 8'h80;
	localparam logic [DATA_W-1:0] R_FRAMES_MF = 8'h0F;
	localparam logic [DATA_W-1:0] R_RES_CTRL  = 8'h4D;

	// Fixed read-only values, encoded as the value minus one where the link does so.
	localparam logic [DATA_W-1:0] V_TOT_BITS  = 8'h0F;
	localparam logic [DATA_W-1:0] V_SAMPLES   = 8'h00;
	localparam logic [DATA_W-1:0] V_DENSITY   = 8'h00;

	// Encoded octets per frame for each converter and lane setting.
	localparam logic [DATA_W-1:0] F_ONE    = 8'h00;
	localparam logic [DATA_W-1:0] F_TWO    = 8'h01;
	localparam logic [DATA_W-1:0] F_FOUR   = 8'h03;

	// One register access from the serial control port.
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} jlpr_req_t;

	// Link configuration handed to the serial transmitter.
	typedef struct packed {
		logic [DATA_W-1:0] bank_id;
		logic [DATA_W-1:0] lane0_id;
		logic [DATA_W-1:0] lane1_id;
		logic              scr_en;
		logic              two_lanes;
		logic              two_conv;
		logic [DATA_W-1:0] octets_enc;
		logic [DATA_W-1:0] frames_enc;
		logic [DATA_W-1:0] res_ctrl;
		logic [DATA_W-1:0] chk0;
		logic [DATA_W-1:0] chk1;
	} jlpr_cfg_t;

endpackage : jlpr_pkg

// [verilog/jlpr_regs.sv]
// Purpose: Link parameter register bank reporting the serial link configuration.
// Assumes: Requests are synchronous to clk; wr and rd are one-cycle strobes.
// Notes:   Read data is registered and valid one cycle after the read strobe.
// Operation
// - Each of lane 0 and lane 1 has its own writable identifier, reported as that lane's identity.
// - Software sets how many frames form a multiframe, and the transmitter uses that value.
// - Samples per converter per frame is read only and always reports one sample.
// - The high-density flag is read only and always reads zero.
// - Two eight-bit scratch fields are freely written and read back, and reset to zero.
// - The lane control bit picks one lane per link when clear and two lanes when set.
// - The top bit of the scrambler and lane register enables scrambling and reports it as one.
module jlpr_regs
(
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire jlpr_pkg::jlpr_req_t req,
	output logic [jlpr_pkg::DATA_W-1:0] rdata,
	output logic                    rvalid,
	output jlpr_pkg::jlpr_cfg_t     cfg
);
	import jlpr_pkg::*;

	logic [DATA_W-1:0] bank_id_r;
	logic [DATA_W-1:0] lane0_id_r;
	logic [DATA_W-1:0] lane1_id_r;
	logic [DATA_W-1:0] scr_lane_r;
	logic [DATA_W-1:0] frames_r;
	logic [DATA_W-1:0] conv_r;
	logic [DATA_W-1:0] res_ctrl_r;
	logic [DATA_W-1:0] scratch1_r;
	logic [DATA_W-1:0] scratch2_r;
	logic [DATA_W-1:0] chk0_r;
	logic [DATA_W-1:0] chk1_r;
	logic [DATA_W-1:0] rdata_r;
	logic              rvalid_r;

	logic [DATA_W-1:0] rdata_nxt;
	logic [DATA_W-1:0] octets_enc;
	logic [DATA_W-1:0] common_sum;
	logic [DATA_W-1:0] chk0_nxt;
	logic [DATA_W-1:0] chk1_nxt;
	logic              two_lanes;
	logic              two_conv;

	// Write strobes per register.
	wire we_bank   = req.wr && (req.addr == A_BANK_ID);
	wire we_lane0  = req.wr && (req.addr == A_LANE0_ID);
	wire we_lane1  = req.wr && (req.addr == A_LANE1_ID);
	wire we_scr    = req.wr && (req.addr == A_SCR_LANE);
	wire we_frames = req.wr && (req.addr == A_FRAMES_MF);
	wire we_conv   = req.wr && (req.addr == A_CONV);
	wire we_res    = req.wr && (req.addr == A_RES_CTRL);
	wire we_scr1   = req.wr && (req.addr == A_SCRATCH1);
	wire we_scr2   = req.wr && (req.addr == A_SCRATCH2);

	// Decoded link settings.
	assign two_lanes = scr_lane_r[B_TWO_LANE];
	assign two_conv  = conv_r[B_TWO_CONV];

	// Octets per frame follows M*2/L; the table avoids a divider for four cases.
	assign octets_enc = two_conv ? (two_lanes ? F_TWO : F_FOUR)
	                             : (two_lanes ? F_ONE : F_TWO);

	// Checksum over the parameters shared by both lanes; only the lane identifier differs.
	assign common_sum = DATA_W'(bank_id_r + {7'h00, scr_lane_r[B_SCR_EN]} + {7'h00, two_lanes}
	                    + octets_enc + frames_r + {7'h00, two_conv} + res_ctrl_r
	                    + V_TOT_BITS + V_SAMPLES + V_DENSITY + scratch1_r + scratch2_r);
	assign chk0_nxt = DATA_W'(common_sum + lane0_id_r);
	assign chk1_nxt = DATA_W'(common_sum + lane1_id_r);

	// Read multiplexer; unmapped addresses read zero.
	always_comb
	begin
		case (req.addr)
			A_BANK_ID:   rdata_nxt = bank_id_r;
			A_LANE0_ID:  rdata_nxt = lane0_id_r;
			A_LANE1_ID:  rdata_nxt = lane1_id_r;
			A_SCR_LANE:  rdata_nxt = scr_lane_r;
			A_OCTETS:    rdata_nxt = octets_enc;
			A_FRAMES_MF: rdata_nxt = frames_r;
			A_CONV:      rdata_nxt = conv_r;
			A_RES_CTRL:  rdata_nxt = res_ctrl_r;
			A_TOT_BITS:  rdata_nxt = V_TOT_BITS;
			A_SAMPLES:   rdata_nxt = V_SAMPLES;
			A_DENSITY:   rdata_nxt = V_DENSITY;
			A_SCRATCH1:  rdata_nxt = scratch1_r;
			A_SCRATCH2:  rdata_nxt = scratch2_r;
			A_CHK0:      rdata_nxt = chk0_r;
			A_CHK1:      rdata_nxt = chk1_r;
			default:     rdata_nxt = R_ZERO;
		endcase
	end

	// Writable registers; open bits are masked so they always read zero.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bank_id_r  <= R_ZERO;
			lane0_id_r <= R_ZERO;
			lane1_id_r <= R_ZERO;
			scr_lane_r <= R_SCR_LANE;
			frames_r   <= R_FRAMES_MF;
			conv_r     <= R_ZERO;
			res_ctrl_r <= R_RES_CTRL;
			scratch1_r <= R_ZERO;
			scratch2_r <= R_ZERO;
		end
		else
		begin
			if (we_bank)   bank_id_r  <= req.wdata & M_BANK_ID;
			if (we_lane0)  lane0_id_r <= req.wdata & M_LANE_ID;
			if (we_lane1)  lane1_id_r <= req.wdata & M_LANE_ID;
			if (we_scr)    scr_lane_r <= req.wdata & M_SCR_LANE;
			if (we_frames) frames_r   <= req.wdata & M_FRAMES_MF;
			if (we_conv)   conv_r     <= req.wdata & M_CONV;
			if (we_res)    res_ctrl_r <= req.wdata & M_RES_CTRL;
			if (we_scr1)   scratch1_r <= req.wdata & M_FULL;
			if (we_scr2)   scratch2_r <= req.wdata & M_FULL;
		end
	end

	// Checksums are refreshed every cycle so they lag a write by one clock.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			chk0_r <= R_ZERO;
			chk1_r <= R_ZERO;
		end
		else
		begin
			chk0_r <= chk0_nxt;
			chk1_r <= chk1_nxt;
		end
	end

	// Registered read answer.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rdata_r  <= R_ZERO;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r  <= req.rd ? rdata_nxt : rdata_r;
			rvalid_r <= req.rd;
		end
	end

	assign rdata  = rdata_r;
	assign rvalid = rvalid_r;

	// Configuration to the transmitter comes straight from flip-flops or fixed tables.
	assign cfg.bank_id    = bank_id_r;
	assign cfg.lane0_id   = lane0_id_r;
	assign cfg.lane1_id   = lane1_id_r;
	assign cfg.scr_en     = scr_lane_r[B_SCR_EN];
	assign cfg.two_lanes  = two_lanes;
	assign cfg.two_conv   = two_conv;
	assign cfg.octets_enc = octets_enc;
	assign cfg.frames_enc = frames_r;
	assign cfg.res_ctrl   = res_ctrl_r;
	assign cfg.chk0       = chk0_r;
	assign cfg.chk1       = chk1_r;

	// Checks of the register behaviour.
	property p_lane0_wr;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_LANE0_ID) |=> (cfg.lane0_id == ($past(req.wdata) & M_LANE_ID));
	endproperty
	a_lane0_wr: assert property (p_lane0_wr) else $error("lane 0 id not written");

	property p_lane1_indep;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_LANE0_ID) |=> $stable(cfg.lane1_id);
	endproperty
	a_lane1_indep: assert property (p_lane1_indep) else $error("lane 1 id changed by lane 0 write");

	property p_frames_wr;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_FRAMES_MF) |=> (cfg.frames_enc == ($past(req.wdata) & M_FRAMES_MF));
	endproperty
	a_frames_wr: assert property (p_frames_wr) else $error("frames per multiframe not written");

	property p_totbits_ro;
		@(posedge clk) disable iff (reset)
		(req.rd && req.addr == A_TOT_BITS) |=> (rvalid && rdata == V_TOT_BITS);
	endproperty
	a_totbits_ro: assert property (p_totbits_ro) else $error("total bits per sample wrong");

	property p_samples_ro;
		@(posedge clk) disable iff (reset)
		(req.rd && req.addr == A_SAMPLES) |=> (rdata == V_SAMPLES);
	endproperty
	a_samples_ro: assert property (p_samples_ro) else $error("samples per frame wrong");

	property p_density_ro;
		@(posedge clk) disable iff (reset)
		(req.rd && req.addr == A_DENSITY) |=> (rdata == V_DENSITY);
	endproperty
	a_density_ro: assert property (p_density_ro) else $error("density flag not zero");

	property p_scratch_rb;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_SCRATCH1) ##1 (req.rd && req.addr == A_SCRATCH1 && !req.wr)
		|=> (rdata == $past(req.wdata, 2));
	endproperty
	a_scratch_rb: assert property (p_scratch_rb) else $error("scratch field readback wrong");

	property p_lane_sel;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_SCR_LANE) |=> (cfg.two_lanes == $past(req.wdata[B_TWO_LANE]));
	endproperty
	a_lane_sel: assert property (p_lane_sel) else $error("lane count bit not applied");

	property p_scr_en;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_SCR_LANE) |=> (cfg.scr_en == $past(req.wdata[B_SCR_EN]));
	endproperty
	a_scr_en: assert property (p_scr_en) else $error("scrambler enable not applied");

	property p_octets;
		@(posedge clk) disable iff (reset)
		(cfg.two_conv && !cfg.two_lanes) |-> (cfg.octets_enc == F_FOUR);
	endproperty
	a_octets: assert property (p_octets) else $error("octets per frame wrong");

	property p_lane1_wr;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_LANE1_ID) |=> (cfg.lane1_id == ($past(req.wdata) & M_LANE_ID));
	endproperty
	a_lane1_wr: assert property (p_lane1_wr) else $error("lane 1 id not written");

	property p_lane0_indep;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_LANE1_ID) |=> $stable(cfg.lane0_id);
	endproperty
	a_lane0_indep: assert property (p_lane0_indep) else $error("lane 0 id changed by lane 1 write");

	property p_scratch2_rb;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_SCRATCH2) ##1 (req.rd && req.addr == A_SCRATCH2 && !req.wr)
		|=> (rdata == $past(req.wdata, 2));
	endproperty
	a_scratch2_rb: assert property (p_scratch2_rb) else $error("second scratch field readback wrong");

	property p_octets_one;
		@(posedge clk) disable iff (reset)
		(!cfg.two_conv && cfg.two_lanes) |-> (cfg.octets_enc == F_ONE);
	endproperty
	a_octets_one: assert property (p_octets_one) else $error("octets per frame wrong for one converter");

	property p_octets_two;
		@(posedge clk) disable iff (reset)
		(cfg.two_conv == cfg.two_lanes) |-> (cfg.octets_enc == F_TWO);
	endproperty
	a_octets_two: assert property (p_octets_two) else $error("octets per frame wrong for matched setting");

	property p_octets_ro;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_OCTETS) |=> $stable(cfg.octets_enc);
	endproperty
	a_octets_ro: assert property (p_octets_ro) else $error("octets per frame changed by a write");

	property p_conv_wr;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_CONV) |=> (cfg.two_conv == $past(req.wdata[B_TWO_CONV]));
	endproperty
	a_conv_wr: assert property (p_conv_wr) else $error("converter count bit not applied");

	// Reset must leave the link settings at their defaults on the first free edge.
	property p_reset_cfg;
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> (cfg.scr_en && !cfg.two_lanes && !cfg.two_conv
		                  && cfg.octets_enc == F_TWO && cfg.frames_enc == R_FRAMES_MF);
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) else $error("link settings not at defaults after reset");

	property p_bank_wr;
		@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_BANK_ID) |=> (cfg.bank_id == ($past(req.wdata) & M_BANK_ID));
	endproperty
	a_bank_wr: assert property (p_bank_wr) else $error("bank id not written");

	property p_rvalid_pulse;
		@(posedge clk) disable iff (reset)
		rvalid == $past(req.rd);
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer not one cycle after strobe");

	// Read data must hold between reads so a slow reader still sees it.
	property p_rdata_hold;
		@(posedge clk) disable iff (reset)
		!$past(req.rd) |-> $stable(rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

	c_two_lanes: cover property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == A_SCR_LANE && req.wdata[B_TWO_LANE]);
	c_scratch: cover property (@(posedge clk) disable iff (reset)
		(req.wr && req.addr == A_SCRATCH2) ##1 (req.rd && req.addr == A_SCRATCH2));
	c_ro_write: cover property (@(posedge clk) disable iff (reset) req.wr && req.addr == A_TOT_BITS);
	c_four_oct: cover property (@(posedge clk) disable iff (reset) cfg.octets_enc == F_FOUR);

endmodule : jlpr_regs

// [verification/jlpr_regs_tb_top.sv]
// Purpose: Self-checking bench for the link parameter register bank.
// Assumes: One clock; requests are driven at the falling edge and taken at the rising edge.
// Notes:   Expected values come from the register table and package constants, never from outputs.
module jlpr_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import jlpr_pkg::*;

	// Reset image of every mapped register, in address order without the checksums.
	localparam logic [ADDR_W-1:0] RST_A [13] = '{A_BANK_ID, A_LANE0_ID, A_LANE1_ID, A_SCR_LANE, A_OCTETS,
		A_FRAMES_MF, A_CONV, A_RES_CTRL, A_TOT_BITS, A_SAMPLES, A_DENSITY, A_SCRATCH1, A_SCRATCH2};
	localparam logic [DATA_W-1:0] RST_V [13] = '{R_ZERO, R_ZERO, R_ZERO, R_SCR_LANE, F_TWO, R_FRAMES_MF,
		R_ZERO, R_RES_CTRL, V_TOT_BITS, V_SAMPLES, V_DENSITY, R_ZERO, R_ZERO};
	localparam logic [ADDR_W-1:0] RO_A [4] = '{A_OCTETS, A_TOT_BITS, A_SAMPLES, A_DENSITY};
	localparam logic [DATA_W-1:0] RO_V [4] = '{F_TWO, V_TOT_BITS, V_SAMPLES, V_DENSITY};
	// Encoded octets per frame, indexed by {two converters, two lanes}.
	localparam logic [DATA_W-1:0] F_TAB [4] = '{F_TWO, F_ONE, F_FOUR, F_TWO};

	logic              clk;
	logic              reset;
	jlpr_req_t         req;
	logic [DATA_W-1:0] rdata;
	logic              rvalid;
	jlpr_cfg_t         cfg;
	int                fails;
	int                total_checks;
	logic [DATA_W-1:0] exp_sum;

	// Free-running 250 MHz clock.
	initial clk = 1'b0;
	always #2 clk = ~clk;

	jlpr_regs dut_u
	(
		.clk    (clk),
		.reset  (reset),
		.req    (req),
		.rdata  (rdata),
		.rvalid (rvalid),
		.cfg    (cfg)
	);

	// Case equality keeps an unknown from passing as a match.
	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// One write strobe; the idle cycle after it keeps wr from being driven twice in one step.
	task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		req.wr    = 1'b1;
		req.addr  = a;
		req.wdata = d;
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
	endtask : reg_write

	// Read strobe, then the one-cycle answer, then the drop of rvalid.
	task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		req.rd   = 1'b1;
		req.addr = a;
		@(negedge clk);
		req.rd = 1'b0;
		check({7'h00, rvalid}, 8'h01);
		check(rdata, exp);
		@(negedge clk);
		check({7'h00, rvalid}, 8'h00);
	endtask : reg_read

	// Write strobe followed at once by a read of the same register, as the port allows.
	task automatic wr_then_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		req.wr    = 1'b1;
		req.addr  = a;
		req.wdata = d;
		@(negedge clk);
		req.wr = 1'b0;
		req.rd = 1'b1;
		@(negedge clk);
		req.rd = 1'b0;
		check({7'h00, rvalid}, 8'h01);
		check(rdata, d);
		@(negedge clk);
		check({7'h00, rvalid}, 8'h00);
	endtask : wr_then_rd

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	// The whole run is about 130 cycles, so 5000 cycles means a hang.
	initial
	begin
		#20000;
		fails++;
		conclude();
	end

	// Main sequence of register accesses.
	initial
	begin
		fails        = 0;
		total_checks = 0;
		reset        = 1'b1;
		req          = '0;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 13; i++)
			reg_read(RST_A[i], RST_V[i]);
		reg_read(13'h007A, R_ZERO);
		reg_write(A_SCRATCH1, 8'hA5);
		reg_write(A_SCRATCH2, 8'h5A);
		reg_read(A_SCRATCH1, 8'hA5);
		reg_read(A_SCRATCH2, 8'h5A);
		wr_then_rd(A_SCRATCH1, 8'hC3);
		wr_then_rd(A_SCRATCH2, 8'h3C);
		// Open bits of a lane identifier must drop away.
		reg_write(A_LANE0_ID, 8'hFF);
		reg_write(A_LANE1_ID, 8'h0A);
		reg_read(A_LANE0_ID, 8'h1F);
		reg_read(A_LANE1_ID, 8'h0A);
		check(cfg.lane0_id, 8'h1F);
		check(cfg.lane1_id, 8'h0A);
		for (int i = 0; i < 4; i++)
		begin
			reg_write(RO_A[i], 8'hFF);
			reg_read(RO_A[i], RO_V[i]);
		end
		reg_write(A_FRAMES_MF, 8'h07);
		reg_read(A_FRAMES_MF, 8'h07);
		check(cfg.frames_enc, 8'h07);
		reg_write(A_FRAMES_MF, 8'hFF);
		reg_read(A_FRAMES_MF, 8'h1F);
		// Every converter and lane pairing, with the scrambler toggled along the way.
		for (int i = 0; i < 4; i++)
		begin
			reg_write(A_CONV, {7'h00, i[1]});
			reg_write(A_SCR_LANE, {i[0] ^ i[1], 6'h3F, i[0]});
			reg_read(A_SCR_LANE, {i[0] ^ i[1], 6'h00, i[0]});
			reg_read(A_OCTETS, F_TAB[i]);
			check(cfg.octets_enc, F_TAB[i]);
			check({7'h00, cfg.two_lanes}, {7'h00, i[0]});
			check({7'h00, cfg.scr_en}, {7'h00, i[0] ^ i[1]});
			check({7'h00, cfg.two_conv}, {7'h00, i[1]});
		end
		// Open bits of the bank and resolution registers must drop away.
		reg_write(A_BANK_ID, 8'hFF);
		reg_read(A_BANK_ID, 8'h0F);
		reg_write(A_RES_CTRL, 8'hFF);
		reg_read(A_RES_CTRL, 8'hDF);
		check(cfg.bank_id, 8'h0F);
		check(cfg.res_ctrl, 8'hDF);
		// Checksum of the settings now in place: two converters, two lanes, scrambler off.
		exp_sum = DATA_W'(8'h0F + 8'h00 + 8'h01 + F_TWO + 8'h1F + 8'h01 + 8'hDF
		          + V_TOT_BITS + V_SAMPLES + V_DENSITY + 8'hC3 + 8'h3C);
		reg_read(A_CHK0, DATA_W'(exp_sum + 8'h1F));
		reg_read(A_CHK1, DATA_W'(exp_sum + 8'h0A));
		check(cfg.chk0, DATA_W'(exp_sum + 8'h1F));
		check(cfg.chk1, DATA_W'(exp_sum + 8'h0A));
		// A second reset in mid-run must restore the defaults.
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		reg_read(A_SCRATCH1, R_ZERO);
		reg_read(A_SCR_LANE, R_SCR_LANE);
		check(cfg.bank_id, R_ZERO);
		check(cfg.res_ctrl, R_RES_CTRL);
		// Both lane identifiers are zero after reset, so both checksums equal the shared sum.
		exp_sum = DATA_W'(R_ZERO + {7'h00, R_SCR_LANE[B_SCR_EN]} + 8'h00 + F_TWO + R_FRAMES_MF + 8'h00
		          + R_RES_CTRL + V_TOT_BITS + V_SAMPLES + V_DENSITY);
		reg_read(A_CHK0, exp_sum);
		reg_read(A_CHK1, exp_sum);
		conclude();
	end

endmodule : jlpr_regs_tb_top
